// *** hdl/crc_range_params.svh ***
// Constants of the array range check engine
`ifndef CRC_RANGE_PARAMS_SVH
`define CRC_RANGE_PARAMS_SVH
`define CRC_POLY 32'h1EDC6F41
`define CRC_INIT 32'hFFFFFFFF
`define MIN_SPAN 33'h000000003
`define OP_RANGE 8'hA5
`define OP_SUSPEND 8'hB0
`define OP_RESUME 8'h30
`define OP_RDREG 8'h65
`define OP_READ 8'h13
`define OP_SWRST 8'hF0
`define REG_STATUS1 32'h00000010
`define REG_STATUS2 32'h00000011
`define REG_RESULT 32'h00000020
`define BUSY_BIT 0
`define SUSP_BIT 4
`define ABORT_BIT 3
`define ADDR_BYTES 4'h4
`define RANGE_BYTES 4'h9
`define IDLE_READ 8'hFF
`endif

// *** hdl/crc_range_pkg.sv ***
// Types of the array range check engine
package crc_range_pkg;
  typedef enum logic [1:0] {ENG_IDLE, ENG_RUN, ENG_SUSP} engine_state_e;
endpackage

// *** hdl/array_byte_mem.sv ***
// Byte-wide memory array with registered read data
`timescale 1ns/1ps
module array_byte_mem #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge ref_clk_i)
  begin
    if (ce_i && wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= 8'h00;
    end
    else if (ce_i)
    begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule

// *** hdl/crc32_byte_step.sv ***
// One byte step of the check-value, most significant bit first
`timescale 1ns/1ps
`include "crc_range_params.svh"
module crc32_byte_step #(
  parameter logic [31:0] POLY = `CRC_POLY
) (
  input wire logic [31:0] crc_i,
  input wire logic [7:0] data_i,
  output logic [31:0] crc_o
);
  always_comb
  begin
    logic [31:0] c;
    c = crc_i;
    for (int i = 7; i >= 0; i--)
    begin
      // Polynomial division
      // shift with feedback
      c = {c[30:0], 1'h0} ^ ((c[31] ^ data_i[i]) ? POLY : 32'h00000000);
    end
    crc_o = c;
  end
endmodule

// *** hdl/array_range_crc_engine.sv ***
// Serial command front end and range check engine
`timescale 1ns/1ps
`include "crc_range_params.svh"
module array_range_crc_engine #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic array_wr_en_i,
  input wire logic [ADDR_W-1:0] array_wr_addr_i,
  input wire logic [7:0] array_wr_data_i
);
  if (ADDR_W < 4 || ADDR_W > 24)
  begin : g_bad_width
    $error("ADDR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges
  logic [2:0] sck_q;
  logic [2:0] cs_q;
  logic [1:0] si_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sck_q <= 3'h0;
      cs_q <= 3'h7;
      si_q <= 2'h0;
    end
    else if (ce_i)
    begin
      sck_q <= {sck_q[1:0], sck_i};
      cs_q <= {cs_q[1:0], cs_n_i};
      si_q <= {si_q[0], si_i};
    end
  end

  logic active_w;
  logic sck_rise_w;
  logic sck_fall_w;
  logic cs_end_w;
  assign active_w = ~cs_q[1];
  assign sck_rise_w = active_w & sck_q[1] & ~sck_q[2];
  assign sck_fall_w = active_w & ~sck_q[1] & sck_q[2];
  assign cs_end_w = ce_i & cs_q[1] & ~cs_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly
  logic [2:0] bit_cnt_reg;
  logic [6:0] sh_reg;
  logic [3:0] byte_cnt_reg;
  logic [7:0] opcode_reg;
  logic [63:0] arg_reg;
  logic byte_done_w;
  logic [7:0] byte_w;
  assign byte_done_w = ce_i & sck_rise_w & (bit_cnt_reg == 3'h7);
  assign byte_w = {sh_reg, si_q[1]};

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_cnt_reg <= 3'h0;
      sh_reg <= 7'h00;
      byte_cnt_reg <= 4'h0;
      opcode_reg <= 8'h00;
      arg_reg <= 64'h0000000000000000;
    end
    else if (ce_i)
    begin
      if (!active_w)
      begin
        bit_cnt_reg <= 3'h0;
        byte_cnt_reg <= 4'h0;
      end
      else if (sck_rise_w)
      begin
        sh_reg <= byte_w[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7)
        begin
          if (byte_cnt_reg == 4'h0)
          begin
            opcode_reg <= byte_w;
          end
          else if (byte_cnt_reg < `RANGE_BYTES)
          begin
            arg_reg <= {arg_reg[55:0], byte_w};
          end
          if (byte_cnt_reg != 4'hF)
          begin
            byte_cnt_reg <= byte_cnt_reg + 4'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completed commands
  logic whole_w;
  logic range_cmd_w;
  logic susp_cmd_w;
  logic res_cmd_w;
  logic rst_cmd_w;
  logic undersize_w;
  assign whole_w = cs_end_w & (bit_cnt_reg == 3'h0);
  assign range_cmd_w = whole_w & (opcode_reg == `OP_RANGE) & (byte_cnt_reg >= `RANGE_BYTES);
  assign susp_cmd_w = whole_w & (opcode_reg == `OP_SUSPEND) & (byte_cnt_reg == 4'h1);
  assign res_cmd_w = whole_w & (opcode_reg == `OP_RESUME) & (byte_cnt_reg == 4'h1);
  assign rst_cmd_w = whole_w & (opcode_reg == `OP_SWRST) & (byte_cnt_reg == 4'h1);
  assign undersize_w = {1'h0, arg_reg[31:0]} < ({1'h0, arg_reg[63:32]} + `MIN_SPAN);

  ////////////////////////////////////////////////////////////////////////////
  // Range check engine
  crc_range_pkg::engine_state_e state_reg;
  logic [31:0] start_addr_reg;
  logic [31:0] end_addr_reg;
  logic [31:0] cur_reg;
  logic [31:0] crc_reg;
  logic [31:0] crc_next;
  logic [31:0] result_reg;
  logic pend_reg;
  logic abort_reg;
  logic [7:0] mem_rdata;
  logic [ADDR_W-1:0] hrd_addr_reg;
  logic [ADDR_W-1:0] mem_addr_w;
  logic run_w;
  logic consume_w;
  logic done_w;
  assign run_w = (state_reg == crc_range_pkg::ENG_RUN);
  assign consume_w = ce_i & run_w & pend_reg & ~susp_cmd_w & ~rst_cmd_w;
  assign done_w = consume_w & (cur_reg == end_addr_reg);
  assign mem_addr_w = run_w ? cur_reg[ADDR_W-1:0] : hrd_addr_reg;

  array_byte_mem #(.ADDR_W(ADDR_W)) u_mem (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .wr_en_i(array_wr_en_i),
    .wr_addr_i(array_wr_addr_i),
    .wr_data_i(array_wr_data_i),
    .rd_addr_i(mem_addr_w),
    .rd_data_o(mem_rdata)
  );

  crc32_byte_step #(.POLY(`CRC_POLY)) u_step (
    .crc_i(crc_reg),
    .data_i(mem_rdata),
    .crc_o(crc_next)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= crc_range_pkg::ENG_IDLE;
      start_addr_reg <= 32'h00000000;
      end_addr_reg <= 32'h00000000;
      cur_reg <= 32'h00000000;
      crc_reg <= `CRC_INIT;
      pend_reg <= 1'h0;
    end
    else if (ce_i)
    begin
      if (rst_cmd_w)
      begin
        state_reg <= crc_range_pkg::ENG_IDLE;
        crc_reg <= `CRC_INIT;
        pend_reg <= 1'h0;
      end
      else if (range_cmd_w && state_reg == crc_range_pkg::ENG_IDLE)
      begin
        start_addr_reg <= arg_reg[63:32];
        end_addr_reg <= arg_reg[31:0];
        cur_reg <= arg_reg[63:32];
        crc_reg <= `CRC_INIT;
        pend_reg <= 1'h0;
        if (!undersize_w)
        begin
          state_reg <= crc_range_pkg::ENG_RUN;
        end
      end
      else if (susp_cmd_w && run_w)
      begin
        state_reg <= crc_range_pkg::ENG_SUSP;
        pend_reg <= 1'h0;
      end
      else if (res_cmd_w && state_reg == crc_range_pkg::ENG_SUSP)
      begin
        state_reg <= crc_range_pkg::ENG_RUN;
      end
      else if (run_w)
      begin
        // address advances only on consumed byte
        pend_reg <= ~pend_reg;
        if (consume_w)
        begin
          crc_reg <= crc_next;
          cur_reg <= cur_reg + 32'h00000001;
        end
        if (done_w)
        begin
          state_reg <= crc_range_pkg::ENG_IDLE;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      result_reg <= `CRC_INIT;
    end
    else if (done_w)
    begin
      result_reg <= crc_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      abort_reg <= 1'h0;
    end
    else if (ce_i)
    begin
      if (range_cmd_w && state_reg == crc_range_pkg::ENG_IDLE && undersize_w)
      begin
        abort_reg <= 1'h1;
      end
      else if (rst_cmd_w || done_w)
      begin
        abort_reg <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and register read data
  logic [7:0] status1_w;
  logic [7:0] status2_w;
  logic [31:0] reg_sel_w;
  logic [31:0] rd_a_w;
  assign rd_a_w = {arg_reg[23:0], byte_w};

  always_comb
  begin
    status1_w = 8'h00;
    status2_w = 8'h00;
    status1_w[`BUSY_BIT] = run_w;
    status2_w[`SUSP_BIT] = (state_reg == crc_range_pkg::ENG_SUSP);
    status2_w[`ABORT_BIT] = abort_reg;
    case (rd_a_w)
      `REG_STATUS1: reg_sel_w = {4{status1_w}};
      `REG_STATUS2: reg_sel_w = {4{status2_w}};
      `REG_RESULT: reg_sel_w = result_reg;
      default: reg_sel_w = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output path
  logic [7:0] tx_reg;
  logic [31:0] word_reg;
  logic [1:0] fetch_q;
  logic so_reg;
  logic oe_reg;
  logic rdreg_w;
  logic rdarr_w;
  assign rdreg_w = (opcode_reg == `OP_RDREG);
  assign rdarr_w = (opcode_reg == `OP_READ);

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_reg <= 8'h00;
      word_reg <= 32'h00000000;
      fetch_q <= 2'h0;
      hrd_addr_reg <= '0;
      so_reg <= 1'h0;
      oe_reg <= 1'h0;
    end
    else if (ce_i)
    begin
      fetch_q <= {fetch_q[0], 1'h0};
      oe_reg <= active_w & (rdreg_w | rdarr_w) & (byte_cnt_reg > `ADDR_BYTES);
      if (fetch_q[1])
      begin
        tx_reg <= run_w ? `IDLE_READ : mem_rdata;
        hrd_addr_reg <= hrd_addr_reg + 1'h1;
      end
      else if (byte_done_w && rdreg_w && byte_cnt_reg == `ADDR_BYTES)
      begin
        word_reg <= reg_sel_w;
        tx_reg <= reg_sel_w[31:24];
      end
      else if (byte_done_w && rdreg_w && byte_cnt_reg > `ADDR_BYTES)
      begin
        word_reg <= {word_reg[23:0], word_reg[31:24]};
        tx_reg <= word_reg[23:16];
      end
      else if (sck_fall_w)
      begin
        so_reg <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'h0};
      end
      if (byte_done_w && rdarr_w && byte_cnt_reg >= `ADDR_BYTES)
      begin
        fetch_q[0] <= 1'h1;
        if (byte_cnt_reg == `ADDR_BYTES)
        begin
          hrd_addr_reg <= rd_a_w[ADDR_W-1:0];
        end
      end
    end
  end

  assign so_o = so_reg;
  assign so_oe_o = oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_start_on_cs: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    range_cmd_w && state_reg == crc_range_pkg::ENG_IDLE && !undersize_w && !rst_cmd_w
    |=> run_w && status1_w[`BUSY_BIT] && cur_reg == start_addr_reg)
    else $error("range check did not start");

  a_range_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    range_cmd_w && state_reg == crc_range_pkg::ENG_IDLE
    |=> start_addr_reg == $past(arg_reg[63:32]) && end_addr_reg == $past(arg_reg[31:0]))
    else $error("range addresses not latched");

  a_abort_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    range_cmd_w && state_reg == crc_range_pkg::ENG_IDLE && undersize_w
    |=> abort_reg && !run_w && status2_w[`ABORT_BIT])
    else $error("undersized range not aborted");

  a_abort_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    abort_reg && !rst_cmd_w && !done_w |=> abort_reg)
    else $error("aborted flag dropped");

  a_busy_done: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    done_w |=> !status1_w[`BUSY_BIT] && result_reg == $past(crc_next) && !abort_reg)
    else $error("completion not reported");

  a_susp_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    susp_cmd_w && run_w && !rst_cmd_w
    |=> status2_w[`SUSP_BIT] && !run_w && $stable(cur_reg) && $stable(crc_reg))
    else $error("suspend not taken");

  a_resume_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    res_cmd_w && state_reg == crc_range_pkg::ENG_SUSP && !rst_cmd_w
    |=> run_w && $stable(cur_reg) && $stable(crc_reg) ##1 ce_i [*2] ##0 pend_reg == 1'h0)
    else $error("resume lost partial state");

  a_idle_only: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    range_cmd_w && state_reg != crc_range_pkg::ENG_IDLE && !rst_cmd_w
    |=> $stable(start_addr_reg) && $stable(end_addr_reg))
    else $error("range check accepted while busy");

  a_addr_span: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    run_w |-> cur_reg >= start_addr_reg && cur_reg <= end_addr_reg)
    else $error("address outside range");
endmodule

// *** dv/host_link_model.sv ***
// Host side serial link driver for the range check engine
`timescale 1ns/1ps
module host_link_model (
  input wire logic ref_clk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // whole bytes in one frame
  task automatic frame(input logic [71:0] tx, input int ntx, input int nrd,
                       output logic [31:0] rx);
    int i;
    rx = 32'h00000000;
    @(posedge ref_clk_i);
    cs_n_o <= 1'b0;
    for (i = 0; i < (ntx + nrd) * 8; i++)
    begin
      si_o <= (i < ntx * 8) ? tx[71 - i] : i[0];
      repeat (4) @(posedge ref_clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      rx = {rx[30:0], so_i};
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    repeat (12) @(posedge ref_clk_i);
  endtask
endmodule

// *** dv/test_array_range_crc_engine.sv ***
// Self-checking bench for the array range check engine
`timescale 1ns/1ps
`include "crc_range_params.svh"
module test_array_range_crc_engine;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic we = 1'b0;
  logic [11:0] wa = 12'h000;
  logic [7:0] wd = 8'h00;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;
  logic [7:0] mem [4096];
  logic [31:0] v;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int s;
  int e;
  int k;

  always #5 ref_clk = ~ref_clk;
  assign so_line = so_oe ? so : ~so;

  array_range_crc_engine #(.ADDR_W(12)) array_range_crc_engine_i (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(1'b1), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .array_wr_en_i(we), .array_wr_addr_i(wa), .array_wr_data_i(wd));
  host_link_model host_link_model_i (
    .ref_clk_i(ref_clk), .so_i(so_line), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] crc_of(input int a0, input int a1);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int a = a0; a <= a1; a++)
    begin
      c = c ^ {mem[a], 24'h000000};
      for (int b = 0; b < 8; b++)
        c = c[31] ? ((c << 1) ^ 32'h1EDC6F41) : (c << 1);
    end
    return c;
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_reg(input logic [31:0] adr, input int n);
    host_link_model_i.frame({`OP_RDREG, adr, 32'h00000000}, 5, n, v);
  endtask

  task automatic cmd(input logic [7:0] op);
    host_link_model_i.frame({op, 64'h0000000000000000}, 1, 0, v);
  endtask

  task automatic start_range(input int a0, input int a1);
    host_link_model_i.frame({`OP_RANGE, 32'(a0), 32'(a1)}, 9, 0, v);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 20; i++)
    begin
      rd_reg(`REG_STATUS1, 1);
      if (v[`BUSY_BIT] === 1'b0)
        break;
    end
    check("busy end", 32'h00000000, 32'(v[`BUSY_BIT]));
  endtask

  task automatic run_check(input int a0, input int a1);
    start_range(a0, a1);
    wait_idle();
    rd_reg(`REG_RESULT, 4);
    check("result", crc_of(a0, a1), v);
    rd_reg(`REG_STATUS2, 1);
    check("abort clear", 32'h00000000, 32'(v[`ABORT_BIT]));
  endtask

  task automatic close_out();
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      miscompares++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hC229A618));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 4096; k++)
    begin
      @(posedge ref_clk);
      mem[k] = 8'($urandom);
      we <= 1'b1;
      wa <= 12'(k);
      wd <= mem[k];
    end
    @(posedge ref_clk);
    we <= 1'b0;
    rd_reg(`REG_RESULT, 4);
    check("result reset", 32'hFFFFFFFF, v);
    for (k = 0; k < 5; k++)
    begin
      s = (k == 0) ? 0 : (k == 1) ? 4092 : $urandom_range(3000);
      e = (k < 2) ? s + 3 : s + 3 + $urandom_range(200);
      run_check(s, e);
    end
    start_range(200, 202);
    host_link_model_i.frame({`OP_SWRST, 64'h0000000000000000}, 2, 0, v);
    rd_reg(`REG_STATUS2, 1);
    check("abort set", 32'h00000001, 32'(v[`ABORT_BIT]));
    rd_reg(`REG_STATUS1, 1);
    check("abort busy", 32'h00000000, 32'(v[`BUSY_BIT]));
    cmd(`OP_SWRST);
    rd_reg(`REG_STATUS2, 1);
    check("abort reset", 32'h00000000, 32'(v[`ABORT_BIT]));
    start_range(500, 501);
    run_check(10, 40);
    host_link_model_i.frame({`OP_RANGE, 32'h00000064, 32'h0000044C}, 9, 1, v);
    rd_reg(`REG_STATUS1, 1);
    check("busy run", 32'h00000001, 32'(v[`BUSY_BIT]));
    host_link_model_i.frame({`OP_READ, 32'h00000000, 32'h00000000}, 5, 4, v);
    check("busy read", {4{`IDLE_READ}}, v);
    cmd(`OP_SUSPEND);
    rd_reg(`REG_STATUS2, 1);
    check("suspended", 32'h00000001, 32'(v[`SUSP_BIT]));
    rd_reg(`REG_STATUS1, 1);
    check("busy susp", 32'h00000000, 32'(v[`BUSY_BIT]));
    s = $urandom_range(4000);
    host_link_model_i.frame({`OP_READ, 32'(s), 32'h00000000}, 5, 4, v);
    check("array read", {mem[s], mem[s + 1], mem[s + 2], mem[s + 3]}, v);
    start_range(0, 10);
    cmd(`OP_RESUME);
    wait_idle();
    rd_reg(`REG_RESULT, 4);
    check("resumed result", crc_of(100, 1100), v);
    rd_reg(32'h00000030, 4);
    check("unmapped", 32'h00000000, v);
    check("so_oe idle", 32'h00000000, 32'(so_oe));
    start_range(300, 301);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_reg(`REG_STATUS2, 1);
    check("abort hw reset", 32'h00000000, 32'(v[`ABORT_BIT]));
    rd_reg(`REG_RESULT, 4);
    check("result hw reset", 32'hFFFFFFFF, v);
    close_out();
  end
endmodule
